// ===== design/rpm_pkg.sv
// Shared constants, types and helpers of the reflex timing unit
package rpm_pkg;
	// Clock and 0.1 ms time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 100000;
	localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IVAL_W = 16;

	// Register byte addresses
	localparam logic [7:0] OFS_PWM_FIRST = 8'h00;
	localparam logic [7:0] OFS_PWM_SECOND = 8'h04;
	localparam logic [7:0] OFS_UDS_FIRST = 8'h08;
	localparam logic [7:0] OFS_UDS_SECOND = 8'h0C;
	localparam logic [7:0] OFS_SPM_FIRST = 8'h10;
	localparam logic [7:0] OFS_SPM_SECOND = 8'h14;
	localparam logic [7:0] OFS_STATE = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;

	// Interval reset values, in ticks
	localparam logic [15:0] RST_PWM_FIRST = 16'h000A;
	localparam logic [15:0] RST_PWM_SECOND = 16'h0005;
	localparam logic [15:0] RST_UDS_FIRST = 16'h0064;
	localparam logic [15:0] RST_UDS_SECOND = 16'h0032;
	localparam logic [15:0] RST_SPM_FIRST = 16'h0032;
	localparam logic [15:0] RST_SPM_SECOND = 16'h0064;

	// Interrupt bits
	localparam int IRQ_N = 3;
	localparam int IRQ_UDS_STOP = 0;
	localparam int IRQ_SPM_FAST = 1;
	localparam int IRQ_SPM_SLOW = 2;
	localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;

	// State register fields
	localparam int ST_OUT_LSB = 0;
	localparam int ST_IN_LSB = 8;

	typedef logic [15:0] rpm_ival_t;
	typedef enum logic [1:0] {UDS_IDLE, UDS_MASK, UDS_WATCH, UDS_STOP} rpm_uds_e;
	typedef enum logic [1:0] {SPM_IDLE, SPM_LOW, SPM_HIGH} rpm_spm_e;

	// Saturating tick count increment
	function automatic rpm_ival_t rpm_inc(input rpm_ival_t v);
		rpm_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction
endpackage

// ===== design/rpm_edge_if.sv
// Synchronised level and edge strobes of one input pin
`timescale 1ns/1ns
`default_nettype none
interface rpm_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport snk (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== design/rpm_sync_edge.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none
module rpm_sync_edge (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic pin,
	rpm_edge_if.src edge_o
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// [R17] sync then edge
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign edge_o.level = sync_r;
	assign edge_o.rise = sync_r & ~last_r;
	assign edge_o.fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// ===== design/rpm_tick.sv
// Divider producing the 0.1 ms tick strobe
`timescale 1ns/1ns
`default_nettype none
module rpm_tick #(
	parameter int unsigned TICK_CYCLES = rpm_pkg::TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	output logic tick
);
	logic [31:0] div_r;

	// [R16] one-cycle tick
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			div_r <= 32'h0;
			tick <= 1'b0;
		end else if (div_r >= TICK_CYCLES - 32'd1) begin
			div_r <= 32'h0;
			tick <= 1'b1;
		end else begin
			div_r <= div_r + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== design/rpm_reflex_top.sv
// Reflex timing unit: pulse-width generator, underspeed detector, speed monitor
// Operation
// [R1] Generator output period is first_interval ticks, high for second_interval ticks.
// [R2] Generator enable rising edge starts oscillation and sets its auxiliary flag.
// [R3] Generator enable low holds output low and clears auxiliary flag.
// [R4] Generator output stays high when second_interval is not below first_interval.
// [R5] Period counted in 0.1 ms ticks; controller programs 5 to 65535.
// [R6] High time counted in 0.1 ms ticks; controller programs 2 to 65534.
// [R7] Detector enable rising edge starts first_interval masking and raises its output.
// [R8] After masking, every feedback edge restarts the second_interval timeout.
// [R9] Detector timeout expiry drops output and raises auxiliary end-of-movement flag.
// [R10] Detector or monitor enable low forces both its outputs low.
// [R11] Monitor enable rising edge starts first_interval timeout and raises its output.
// [R12] Low-speed monitor restarts first_interval timeout on each feedback rising edge.
// [R13] Feedback edges closer than first_interval raise speed output, start second_interval.
// [R14] High-speed monitor restarts on edges; gap beyond second_interval drops speed output.
// [R15] Controller keeps monitor second_interval strictly above first_interval.
// [R16] A one-cycle 0.1 ms tick advances every interval counter.
// [R17] Enable and feedback pins are synchronised and edge-detected against registered copies.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module rpm_reflex_top #(
	parameter int unsigned TICK_CYCLES = rpm_pkg::TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [rpm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rpm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rpm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic pwm_enable,
	input wire logic uds_enable,
	input wire logic uds_feedback,
	input wire logic spm_enable,
	input wire logic spm_feedback,
	output logic pwm_out,
	output logic pwm_aux,
	output logic uds_out,
	output logic uds_aux,
	output logic spm_out,
	output logic spm_aux,
	output logic irq
);
	import rpm_pkg::*;

	logic tick_w;
	rpm_edge_if pwm_en ();
	rpm_edge_if uds_en ();
	rpm_edge_if uds_fb ();
	rpm_edge_if spm_en ();
	rpm_edge_if spm_fb ();

	// [R16] shared time base
	rpm_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick(tick_w)
	);

	rpm_sync_edge u_pwm_en (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(pwm_enable),
		.edge_o(pwm_en)
	);

	rpm_sync_edge u_uds_en (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(uds_enable),
		.edge_o(uds_en)
	);

	rpm_sync_edge u_uds_fb (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(uds_feedback),
		.edge_o(uds_fb)
	);

	rpm_sync_edge u_spm_en (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(spm_enable),
		.edge_o(spm_en)
	);

	rpm_sync_edge u_spm_fb (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pin(spm_feedback),
		.edge_o(spm_fb)
	);

	// Interval registers, in ticks; interrupt and read-back state
	rpm_ival_t pwm_first_r;
	rpm_ival_t pwm_second_r;
	rpm_ival_t uds_first_r;
	rpm_ival_t uds_second_r;
	rpm_ival_t spm_first_r;
	rpm_ival_t spm_second_r;
	logic [IRQ_N-1:0] irq_stat_r;
	logic [IRQ_N-1:0] irq_en_r;
	logic [IRQ_N-1:0] irq_clr_w;
	logic [IRQ_N-1:0] irq_evt_w;
	logic [DATA_W-1:0] rd_mux_w;
	logic [DATA_W-1:0] reg_rdata_r;
	logic irq_r;

	// Generator state
	logic pwm_run_r;
	rpm_ival_t pwm_cnt_r;
	logic pwm_out_r;

	// Detector state
	rpm_uds_e uds_state_r;
	rpm_ival_t uds_cnt_r;
	logic uds_out_r;
	logic uds_aux_r;
	logic uds_stop_w;

	// Monitor state
	rpm_spm_e spm_state_r;
	rpm_ival_t spm_cnt_r;
	logic spm_seen_r;
	logic spm_out_r;
	logic spm_aux_r;
	logic spm_fast_w;
	logic spm_slow_w;

	// Configuration writes
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pwm_first_r <= RST_PWM_FIRST;
			pwm_second_r <= RST_PWM_SECOND;
			uds_first_r <= RST_UDS_FIRST;
			uds_second_r <= RST_UDS_SECOND;
			spm_first_r <= RST_SPM_FIRST;
			spm_second_r <= RST_SPM_SECOND;
			irq_en_r <= RST_IRQ_ENABLE;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_PWM_FIRST: pwm_first_r <= reg_wdata[IVAL_W-1:0];
				OFS_PWM_SECOND: pwm_second_r <= reg_wdata[IVAL_W-1:0];
				OFS_UDS_FIRST: uds_first_r <= reg_wdata[IVAL_W-1:0];
				OFS_UDS_SECOND: uds_second_r <= reg_wdata[IVAL_W-1:0];
				OFS_SPM_FIRST: spm_first_r <= reg_wdata[IVAL_W-1:0];
				OFS_SPM_SECOND: spm_second_r <= reg_wdata[IVAL_W-1:0];
				OFS_IRQ_ENABLE: irq_en_r <= reg_wdata[IRQ_N-1:0];
				default: ;
			endcase
		end
	end

	assign irq_clr_w = (reg_wr && reg_addr == OFS_IRQ_CLEAR) ? reg_wdata[IRQ_N-1:0] : '0;

	// Read multiplexer; unmapped and write-only addresses read zero
	always_comb begin
		rd_mux_w = '0;
		unique case (reg_addr)
			OFS_PWM_FIRST: rd_mux_w[IVAL_W-1:0] = pwm_first_r;
			OFS_PWM_SECOND: rd_mux_w[IVAL_W-1:0] = pwm_second_r;
			OFS_UDS_FIRST: rd_mux_w[IVAL_W-1:0] = uds_first_r;
			OFS_UDS_SECOND: rd_mux_w[IVAL_W-1:0] = uds_second_r;
			OFS_SPM_FIRST: rd_mux_w[IVAL_W-1:0] = spm_first_r;
			OFS_SPM_SECOND: rd_mux_w[IVAL_W-1:0] = spm_second_r;
			OFS_STATE: begin
				rd_mux_w[ST_OUT_LSB +: 6] = {spm_aux_r, spm_out_r, uds_aux_r,
					uds_out_r, pwm_run_r, pwm_out_r};
				rd_mux_w[ST_IN_LSB +: 5] = {spm_fb.level, spm_en.level, uds_fb.level,
					uds_en.level, pwm_en.level};
			end
			OFS_IRQ_STATUS: rd_mux_w[IRQ_N-1:0] = irq_stat_r;
			OFS_IRQ_ENABLE: rd_mux_w[IRQ_N-1:0] = irq_en_r;
			default: ;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_rdata_r <= '0;
		end else begin
			reg_rdata_r <= reg_rd ? rd_mux_w : '0;
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle
	assign irq_evt_w = {spm_slow_w, spm_fast_w, uds_stop_w};

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			irq_stat_r <= '0;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_evt_w;
			irq_r <= |(irq_stat_r & irq_en_r);
		end
	end

	// Generator run flag and phase counter
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pwm_run_r <= 1'b0;
			pwm_cnt_r <= '0;
		end else if (!pwm_en.level) begin
			// [R3] stop and clear flag
			pwm_run_r <= 1'b0;
			pwm_cnt_r <= '0;
		end else if (pwm_en.rise) begin
			// [R2] start and set flag
			pwm_run_r <= 1'b1;
			pwm_cnt_r <= '0;
		end else if (pwm_run_r && tick_w) begin
			// [R5] period wraps in ticks
			if (rpm_inc(pwm_cnt_r) >= pwm_first_r) begin
				pwm_cnt_r <= '0;
			end else begin
				pwm_cnt_r <= rpm_inc(pwm_cnt_r);
			end
		end
	end

	// Generator output
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pwm_out_r <= 1'b0;
		end else if (!pwm_run_r || !pwm_en.level) begin
			// [R3] held low when stopped
			pwm_out_r <= 1'b0;
		end else if (pwm_second_r >= pwm_first_r) begin
			// [R4] permanently high
			pwm_out_r <= 1'b1;
		end else begin
			// [R1] [R6] high for the first second_interval ticks
			pwm_out_r <= pwm_cnt_r < pwm_second_r;
		end
	end

	// [R9] timeout expiry with no restarting edge
	assign uds_stop_w = uds_en.level && !uds_en.rise && uds_state_r == UDS_WATCH &&
		!(uds_fb.rise || uds_fb.fall) && tick_w && rpm_inc(uds_cnt_r) >= uds_second_r;

	// Underspeed detector
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			uds_state_r <= UDS_IDLE;
			uds_cnt_r <= '0;
			uds_out_r <= 1'b0;
			uds_aux_r <= 1'b0;
		end else if (!uds_en.level) begin
			// [R10] disable clears both
			uds_state_r <= UDS_IDLE;
			uds_cnt_r <= '0;
			uds_out_r <= 1'b0;
			uds_aux_r <= 1'b0;
		end else if (uds_en.rise) begin
			// [R7] start masking
			uds_state_r <= UDS_MASK;
			uds_cnt_r <= '0;
			uds_out_r <= 1'b1;
			uds_aux_r <= 1'b0;
		end else begin
			unique case (uds_state_r)
				UDS_IDLE, UDS_STOP: ;
				UDS_MASK: begin
					if (tick_w) begin
						if (rpm_inc(uds_cnt_r) >= uds_first_r) begin
							uds_state_r <= UDS_WATCH;
							uds_cnt_r <= '0;
						end else begin
							uds_cnt_r <= rpm_inc(uds_cnt_r);
						end
					end
				end
				UDS_WATCH: begin
					if (uds_fb.rise || uds_fb.fall) begin
						// [R8] any edge restarts timeout
						uds_cnt_r <= '0;
					end else if (uds_stop_w) begin
						// [R9] end of movement
						uds_state_r <= UDS_STOP;
						uds_out_r <= 1'b0;
						uds_aux_r <= 1'b1;
					end else if (tick_w) begin
						uds_cnt_r <= rpm_inc(uds_cnt_r);
					end
				end
			endcase
		end
	end

	// [R13] close pair of rising edges
	assign spm_fast_w = spm_en.level && !spm_en.rise && spm_state_r == SPM_LOW &&
		spm_fb.rise && spm_seen_r && spm_cnt_r < spm_first_r;
	// [R14] gap beyond second_interval
	assign spm_slow_w = spm_en.level && !spm_en.rise && spm_state_r == SPM_HIGH &&
		!spm_fb.rise && tick_w && rpm_inc(spm_cnt_r) > spm_second_r;

	// Speed monitor
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			spm_state_r <= SPM_IDLE;
			spm_cnt_r <= '0;
			spm_seen_r <= 1'b0;
			spm_out_r <= 1'b0;
			spm_aux_r <= 1'b0;
		end else if (!spm_en.level) begin
			// [R10] disable clears both
			spm_state_r <= SPM_IDLE;
			spm_cnt_r <= '0;
			spm_seen_r <= 1'b0;
			spm_out_r <= 1'b0;
			spm_aux_r <= 1'b0;
		end else if (spm_en.rise) begin
			// [R11] start low-speed timing
			spm_state_r <= SPM_LOW;
			spm_cnt_r <= '0;
			spm_seen_r <= 1'b0;
			spm_out_r <= 1'b1;
			spm_aux_r <= 1'b0;
		end else begin
			unique case (spm_state_r)
				SPM_IDLE: ;
				SPM_LOW: begin
					if (spm_fast_w) begin
						// [R13] enter high speed
						spm_state_r <= SPM_HIGH;
						spm_aux_r <= 1'b1;
						spm_cnt_r <= '0;
					end else if (spm_fb.rise) begin
						// [R12] restart first_interval timeout
						spm_cnt_r <= '0;
						spm_seen_r <= 1'b1;
					end else if (tick_w) begin
						spm_cnt_r <= rpm_inc(spm_cnt_r);
					end
				end
				SPM_HIGH: begin
					if (spm_fb.rise) begin
						// [R14] restart second_interval timeout
						spm_cnt_r <= '0;
					end else if (spm_slow_w) begin
						// [R14] back to low speed
						spm_state_r <= SPM_LOW;
						spm_aux_r <= 1'b0;
						spm_cnt_r <= '0;
						spm_seen_r <= 1'b0;
					end else if (tick_w) begin
						spm_cnt_r <= rpm_inc(spm_cnt_r);
					end
				end
			endcase
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign pwm_out = pwm_out_r;
	assign pwm_aux = pwm_run_r;
	assign uds_out = uds_out_r;
	assign uds_aux = uds_aux_r;
	assign spm_out = spm_out_r;
	assign spm_aux = spm_aux_r;
	assign irq = irq_r;
endmodule
`default_nettype wire

// ===== sim/rpm_reflex_props.sv
// Port-level assertions of the reflex timing unit
`timescale 1ns/1ns
`default_nettype none
module rpm_reflex_props #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic reg_rd,
	input wire logic [rpm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic pwm_enable,
	input wire logic uds_enable,
	input wire logic spm_enable,
	input wire logic pwm_out,
	input wire logic pwm_aux,
	input wire logic uds_out,
	input wire logic uds_aux,
	input wire logic spm_out,
	input wire logic spm_aux
);
	import rpm_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Enable rose and stayed up long enough to pass the synchroniser
	sequence s_rise(en);
		$rose(en) ##0 en[*6];
	endsequence
	sequence s_low(en);
		!en[*6];
	endsequence
	a_pwm_start: assert property (s_rise(pwm_enable) |-> pwm_aux)
		else $error("generator flag low after enable");
	a_uds_start: assert property (s_rise(uds_enable) |-> uds_out)
		else $error("detector output low after enable");
	a_spm_start: assert property (s_rise(spm_enable) |-> spm_out)
		else $error("monitor output low after enable");
	a_pwm_off: assert property (s_low(pwm_enable) |-> !pwm_out && !pwm_aux)
		else $error("generator active while disabled");
	a_uds_off: assert property (s_low(uds_enable) |-> !uds_out && !uds_aux)
		else $error("detector active while disabled");
	a_spm_off: assert property (s_low(spm_enable) |-> !spm_out && !spm_aux)
		else $error("monitor active while disabled");
	a_pwm_gated: assert property (pwm_out && !pwm_aux |=> !pwm_out)
		else $error("generator pulses without its flag");
	a_spm_gated: assert property (spm_aux && !spm_out |=> !spm_aux)
		else $error("speed output without monitor output");
	a_uds_stop: assert property (uds_aux |-> !uds_out)
		else $error("detector stop flag with output high");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0) // Register port
		else $error("read data outside read cycle");
	// Two synchroniser stages plus the run flag register: flag rises exactly three clocks late
	a_sync_delay: assert property ($rose(pwm_enable) ##1 pwm_enable[*3] |-> $rose(pwm_aux))
		else $error("enable edge not seen after two sync stages");
endmodule
`default_nettype wire

// ===== sim/rpm_sensor.sv
// Machine pulse sensor driving one feedback pin
`timescale 1ns/1ns
`default_nettype none
module rpm_sensor (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [7:0] gap,
	output logic fb
);
	logic [7:0] cnt_r;
	// One rising edge every gap clocks; gap of 4 or more keeps pulses visible
	always_ff @(posedge clk_sys) begin
		if (!run || cnt_r >= gap - 8'h01) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	// A stopped machine leaves the pin low
	always_ff @(posedge clk_sys) begin
		fb <= run && (cnt_r < (gap >> 1));
	end
endmodule
`default_nettype wire

// ===== sim/rpm_reflex_top_tb.sv
// Self-checking bench of the reflex timing unit
`timescale 1ns/1ns
`default_nettype none
module rpm_reflex_top_tb;
	import rpm_pkg::*;
	localparam int unsigned TK = 4;
	localparam rpm_ival_t RST_TAB [6] = '{RST_PWM_FIRST, RST_PWM_SECOND, RST_UDS_FIRST,
		RST_UDS_SECOND, RST_SPM_FIRST, RST_SPM_SECOND};
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pwm_enable = 1'b0;
	logic uds_enable = 1'b0;
	logic spm_enable = 1'b0;
	logic uds_run = 1'b0;
	logic spm_run = 1'b0;
	logic [7:0] uds_gap = 8'h10;
	logic [7:0] spm_gap = 8'h18;
	logic [DATA_W-1:0] reg_rdata;
	logic uds_feedback, spm_feedback, pwm_out, pwm_aux, uds_out, uds_aux, spm_out, spm_aux, irq;
	logic [5:0] outs;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	assign outs = {pwm_out, pwm_aux, uds_out, uds_aux, spm_out, spm_aux};
	always #5 clk_sys = ~clk_sys;
	rpm_reflex_top #(.TICK_CYCLES(TK)) rpm_reflex_top_i (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .pwm_enable, .uds_enable, .uds_feedback, .spm_enable,
		.spm_feedback, .pwm_out, .pwm_aux, .uds_out, .uds_aux, .spm_out, .spm_aux, .irq);
	rpm_sensor uds_sensor_i (.clk_sys, .run(uds_run), .gap(uds_gap), .fb(uds_feedback));
	rpm_sensor spm_sensor_i (.clk_sys, .run(spm_run), .gap(spm_gap), .fb(spm_feedback));
	task automatic test_done();
		$display("Checks %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Waits n clocks, then compares the six block outputs
	task automatic chko(input int n, input logic [5:0] exp);
		repeat (n) @(posedge clk_sys);
		#1;
		chk({26'h0, outs}, {26'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// Counts clocks while the generator output holds level v
	task automatic lvl(input logic v, output int n);
		n = 0;
		while (pwm_out === v && n < 200) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask
	initial begin
		int hi, lo;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), {16'h0, RST_TAB[i]});
		end
		rd(OFS_IRQ_ENABLE, 32'h0);
		rd(8'hFC, 32'h0);
		wr(OFS_PWM_FIRST, 32'hABCD0005);
		rd(OFS_PWM_FIRST, 32'h5);
		wr(OFS_PWM_SECOND, 32'h2);
		@(posedge clk_sys);
		pwm_enable <= 1'b1;
		// Tick phase is free running, so only the generator output is left unchecked here
		repeat (8) @(posedge clk_sys);
		#1;
		chk({26'h0, outs & 6'b011111}, 32'h10);
		lvl(1'b1, hi);
		lvl(1'b0, lo);
		lvl(1'b1, hi);
		lvl(1'b0, lo);
		chk(hi, 2 * TK);
		chk(lo, 3 * TK);
		wr(OFS_PWM_SECOND, 32'h5);
		repeat (30) @(posedge clk_sys);
		#1;
		lvl(1'b1, hi);
		chk(hi, 200);
		@(posedge clk_sys);
		pwm_enable <= 1'b0;
		chko(6, 6'b000000);
		wr(OFS_UDS_FIRST, 32'h3);
		wr(OFS_UDS_SECOND, 32'h4);
		@(posedge clk_sys);
		uds_enable <= 1'b1;
		uds_run <= 1'b1;
		chko(6, 6'b001000);
		chko(100, 6'b001000);
		@(posedge clk_sys);
		uds_run <= 1'b0;
		chko(40, 6'b000100);
		rd(OFS_IRQ_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({31'h0, irq}, 32'h0);
		rd(OFS_IRQ_STATUS, 32'h0);
		@(posedge clk_sys);
		uds_enable <= 1'b0;
		chko(6, 6'b000000);
		wr(OFS_SPM_FIRST, 32'h4);
		wr(OFS_SPM_SECOND, 32'h8);
		@(posedge clk_sys);
		spm_enable <= 1'b1;
		spm_run <= 1'b1;
		chko(6, 6'b000010);
		chko(150, 6'b000010);
		@(posedge clk_sys);
		spm_gap <= 8'h08;
		chko(60, 6'b000011);
		rd(OFS_IRQ_STATUS, 32'h2);
		@(posedge clk_sys);
		spm_gap <= 8'h18;
		chko(150, 6'b000011);
		@(posedge clk_sys);
		spm_run <= 1'b0;
		chko(60, 6'b000010);
		rd(OFS_IRQ_STATUS, 32'h6);
		// Monitor output high, monitor enable level high, all feedback pins low
		rd(OFS_STATE, 32'h810);
		@(posedge clk_sys);
		spm_enable <= 1'b0;
		chko(6, 6'b000000);
		test_done();
	end
endmodule
bind rpm_reflex_top rpm_reflex_props #(.TICK_CYCLES(TICK_CYCLES)) rpm_reflex_props_i (.clk_sys(clk_sys),
	.reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_enable(pwm_enable),
	.uds_enable(uds_enable), .spm_enable(spm_enable), .pwm_out(pwm_out), .pwm_aux(pwm_aux),
	.uds_out(uds_out), .uds_aux(uds_aux), .spm_out(spm_out), .spm_aux(spm_aux));
`default_nettype wire
